/* File: common/cfsg_map.svh */
// constants for the clock fanout select and gate block
// assumes inclusion by bare name from design files
`ifndef CFSG_MAP_SVH
`define CFSG_MAP_SVH
`define CFSG_NUM_OUTPUTS 5
`define CFSG_GATE_RESET_VAL 1'b0
`define CFSG_STD_LVDS 1'b0
`define CFSG_STD_PECL 1'b1
`endif

/* File: common/cfsg_pkg.sv */
// types for the clock fanout select and gate block
// assumes the map header sits on the include path
package cfsg_pkg;
    typedef enum logic {
        CFSG_LVDS = 1'b0,
        CFSG_PECL = 1'b1
    } cfsg_level_std_t;
    typedef enum logic {
        CFSG_GATE_OPEN = 1'b0,
        CFSG_GATE_SHUT = 1'b1
    } cfsg_gate_t;
endpackage

/* File: rtl/cfsg_fanout.sv */
// clock fanout: source select, falling-edge synchronised gate, five pairs
// assumes input clocks are sampled levels at the 250 MHz system clock;
// pins arrive asynchronous and pass two flip-flops first
// outputs are registered copies, one system clock behind the gated level
`timescale 1ns/1ps
`include "cfsg_map.svh"

// Summary of operation
// - select high routes primary pair, low routes secondary pair.
// - gate input low lets every output pair follow the selected clock.
// - gate input high holds true outputs low, complementary outputs high.
// - gate change applies only on a later falling edge of selected clock.
// - enabled true output is high when selected true is above its comp, complement its inverse.
// - five identical pairs driven from the one selected gated clock.
// - level select low means LVDS standard, high means PECL standard.
// - reset defaults act as pull-downs: secondary source, enabled, LVDS.
module cfsg_fanout (
    input wire logic clock,
    input wire logic nrst,
    input wire logic primary_clock,
    input wire logic primary_clock_n,
    input wire logic secondary_clock,
    input wire logic secondary_clock_n,
    input wire logic source_select,
    input wire logic output_gate_n,
    input wire logic level_select,
    output logic [`CFSG_NUM_OUTPUTS-1:0] fanout_out,
    output logic [`CFSG_NUM_OUTPUTS-1:0] fanout_out_comp,
    output cfsg_pkg::cfsg_level_std_t out_standard
);
    import cfsg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; first stage read only by second
    // clock pins and control pins kept apart, one concern each
    logic [3:0] clk_meta;
    logic [3:0] clk_sync;
    logic [2:0] ctl_meta;
    logic [2:0] ctl_sync;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_meta <= 4'h0;
            clk_sync <= 4'h0;
        end else begin
            clk_meta <= {secondary_clock_n, secondary_clock, primary_clock_n, primary_clock};
            clk_sync <= clk_meta;
        end
    end

    // pull-down defaults: secondary source, outputs enabled, lvds
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl_meta <= 3'h0;
            ctl_sync <= 3'h0;
        end else begin
            ctl_meta <= {level_select, output_gate_n, source_select};
            ctl_sync <= ctl_meta;
        end
    end

    logic p_t;
    logic p_c;
    logic s_t;
    logic s_c;
    logic sel_s;
    logic gate_s;
    logic lvl_s;
    assign p_t = clk_sync[0];
    assign p_c = clk_sync[1];
    assign s_t = clk_sync[2];
    assign s_c = clk_sync[3];
    assign sel_s = ctl_sync[0];
    assign gate_s = ctl_sync[1];
    assign lvl_s = ctl_sync[2];

    ////////////////////////////////////////////////////////////////////
    // source mux; differential sense, true high when true above comp
    // a swap while open can cut a pulse short; neither side is gated off on a swap
    logic sel_level;
    assign sel_level = sel_s ? (p_t & ~p_c) : (s_t & ~s_c);

    logic sel_prev;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_level;
        end
    end

    logic fall_edge;
    assign fall_edge = sel_prev & ~sel_level;

    ////////////////////////////////////////////////////////////////////
    // gate state takes a new value only at a falling edge, so no runt
    cfsg_gate_t gate_state;
    cfsg_gate_t next_gate_state;
    // a request with no falling edge waits; a stopped input keeps it pending
    always_comb begin
        next_gate_state = gate_state;
        unique case (gate_state)
            CFSG_GATE_OPEN: begin
                if (fall_edge && gate_s) begin
                    next_gate_state = CFSG_GATE_SHUT;
                end
            end
            CFSG_GATE_SHUT: begin
                if (fall_edge && !gate_s) begin
                    next_gate_state = CFSG_GATE_OPEN;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gate_state <= cfsg_gate_t'(`CFSG_GATE_RESET_VAL);
        end else begin
            gate_state <= next_gate_state;
        end
    end

    logic gated_level;
    assign gated_level = (gate_state == CFSG_GATE_OPEN) ? sel_level : 1'b0;

    ////////////////////////////////////////////////////////////////////
    // five identical pairs
    // one flop per pin, so all five switch on the same edge
    genvar gi;
    generate
        for (gi = 0; gi < `CFSG_NUM_OUTPUTS; gi++) begin : g_pair
            cfsg_out_pair u_pair (
                .clock(clock),
                .nrst(nrst),
                .level_in(gated_level),
                .q_true(fanout_out[gi]),
                .q_comp(fanout_out_comp[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // static output standard
    // a strap only; it has no effect on clock timing here
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_standard <= cfsg_level_std_t'(`CFSG_STD_LVDS);
        end else begin
            out_standard <= lvl_s ? CFSG_PECL : CFSG_LVDS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_pairs_complement: assert property (@(posedge clock) disable iff (!nrst)
        fanout_out == ~fanout_out_comp)
        else $error("output pair not complementary");

    a_pairs_identical: assert property (@(posedge clock) disable iff (!nrst)
        fanout_out == {`CFSG_NUM_OUTPUTS{fanout_out[0]}})
        else $error("output pairs differ");

    a_shut_holds_low: assert property (@(posedge clock) disable iff (!nrst)
        gate_state == CFSG_GATE_SHUT |=> fanout_out == '0)
        else $error("gated output not low");

    a_shut_comp_high: assert property (@(posedge clock) disable iff (!nrst)
        gate_state == CFSG_GATE_SHUT |=> fanout_out_comp == '1)
        else $error("gated complement not high");

    a_open_follows: assert property (@(posedge clock) disable iff (!nrst)
        gate_state == CFSG_GATE_OPEN |=> fanout_out[0] == $past(sel_level))
        else $error("open output not following clock");

    a_open_comp: assert property (@(posedge clock) disable iff (!nrst)
        gate_state == CFSG_GATE_OPEN |=> fanout_out_comp[0] == !$past(sel_level))
        else $error("open complement not inverse of clock");

    a_gate_on_fall: assert property (@(posedge clock) disable iff (!nrst)
        !fall_edge |=> $stable(gate_state))
        else $error("gate changed without falling edge");

    a_next_needs_fall: assert property (@(posedge clock) disable iff (!nrst)
        next_gate_state != gate_state |-> fall_edge)
        else $error("gate change planned without falling edge");

    a_gate_takes: assert property (@(posedge clock) disable iff (!nrst)
        fall_edge |=> gate_state == cfsg_gate_t'($past(gate_s)))
        else $error("gate not updated on falling edge");

    a_swap_no_runt: assert property (@(posedge clock) disable iff (!nrst)
        fall_edge |=> fanout_out == '0 && fanout_out_comp == '1)
        else $error("gate swapped while output high");

    a_rise_when_open: assert property (@(posedge clock) disable iff (!nrst)
        $rose(fanout_out[0]) |-> $past(sel_level) && $past(gate_state) == CFSG_GATE_OPEN)
        else $error("output rose without open gate and high input");

    a_fall_follows_input: assert property (@(posedge clock) disable iff (!nrst)
        $fell(fanout_out[0]) |-> !$past(sel_level))
        else $error("output fell while input high");

    a_mux_primary: assert property (@(posedge clock) disable iff (!nrst)
        sel_s && gate_state == CFSG_GATE_OPEN |=> fanout_out[0] == $past(p_t & ~p_c))
        else $error("primary not routed");

    a_mux_secondary: assert property (@(posedge clock) disable iff (!nrst)
        !sel_s && gate_state == CFSG_GATE_OPEN |=> fanout_out[0] == $past(s_t & ~s_c))
        else $error("secondary not routed");

    a_level_std: assert property (@(posedge clock) disable iff (!nrst)
        lvl_s |=> out_standard == CFSG_PECL)
        else $error("standard not followed");

    a_level_lvds: assert property (@(posedge clock) disable iff (!nrst)
        !lvl_s |=> out_standard == CFSG_LVDS)
        else $error("low standard not followed");

    a_std_static: assert property (@(posedge clock) disable iff (!nrst)
        $stable(lvl_s) |=> $stable(out_standard))
        else $error("standard moved without select change");
endmodule

/* File: rtl/cfsg_out_pair.sv */
// one differential output pair driver
// assumes gated level arrives unregistered from the parent; registered here
`timescale 1ns/1ps
module cfsg_out_pair (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level_in,
    output logic q_true,
    output logic q_comp
);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q_true <= 1'b0;
            q_comp <= 1'b1;
        end else begin
            q_true <= level_in;
            q_comp <= ~level_in;
        end
    end
endmodule

/* File: tb/cfsg_src.sv */
// upstream model: both differential clock pairs as slow levels
// assumes the bench calls drive just after a falling clock edge
`timescale 1ns/1ps
module cfsg_src (
    output logic pri,
    output logic pri_n,
    output logic sec,
    output logic sec_n
);
    // complements always inverse, so no level ever reads as both high
    task automatic drive(input logic pv, input logic sv);
        pri = pv;
        pri_n = ~pv;
        sec = sv;
        sec_n = ~sv;
    endtask
    initial drive(1'b0, 1'b0);
endmodule

/* File: tb/tb.sv */
// bench for the fanout block: select, gate and level standard
// assumes cfsg_pkg and the map header are compiled first
`timescale 1ns/1ps
module tb;
    import cfsg_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sel = 1'b1;
    logic gate_n = 1'b0;
    logic lvl = 1'b0;
    logic p, p_n, s, s_n;
    logic [4:0] q, qc;
    cfsg_level_std_t std;
    int mismatches = 0;
    int compares = 0;
    always #2 clock = ~clock;
    cfsg_src src (.pri(p), .pri_n(p_n), .sec(s), .sec_n(s_n));
    cfsg_fanout uut (.clock(clock), .nrst(nrst), .primary_clock(p), .primary_clock_n(p_n),
        .secondary_clock(s), .secondary_clock_n(s_n), .source_select(sel),
        .output_gate_n(gate_n), .level_select(lvl), .fanout_out(q),
        .fanout_out_comp(qc), .out_standard(std));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] v);
        compares++;
        if (v !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", nm, e, v);
        end
    endtask
    task automatic chk_std(input cfsg_level_std_t e);
        compares++;
        if (std !== e) begin
            mismatches++;
            $display("unexpected out_standard exp %b got %b", e, std);
        end
    endtask
    // six cycles covers the four-edge path with margin
    task automatic pair(input logic [4:0] e);
        wt(6);
        chk("fanout_out", e, q);
        chk("fanout_out_comp", ~e, qc);
    endtask
    task automatic stop_test();
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        pair(5'h00);
        chk_std(CFSG_LVDS);
    endtask
    task automatic test_primary();
        src.drive(1'b1, 1'b0);
        pair(5'h1f);
        src.drive(1'b0, 1'b1);
        pair(5'h00);
    endtask
    // gate changes wait for a falling edge; source swapped only while shut
    task automatic test_gate();
        src.drive(1'b1, 1'b0);
        pair(5'h1f);
        gate_n = 1'b1;
        pair(5'h1f);
        src.drive(1'b0, 1'b0);
        pair(5'h00);
        sel = 1'b0;
        src.drive(1'b0, 1'b1);
        pair(5'h00);
        gate_n = 1'b0;
        pair(5'h00);
        src.drive(1'b0, 1'b0);
        pair(5'h00);
        src.drive(1'b0, 1'b1);
        pair(5'h1f);
    endtask
    task automatic test_level();
        lvl = 1'b1;
        wt(4);
        chk_std(CFSG_PECL);
        lvl = 1'b0;
        wt(4);
        chk_std(CFSG_LVDS);
    endtask
    // reset mid-run while shut: pull-down defaults reopen the gate
    task automatic test_reset_mid();
        gate_n = 1'b1;
        src.drive(1'b0, 1'b0);
        pair(5'h00);
        lvl = 1'b1;
        src.drive(1'b0, 1'b1);
        pair(5'h00);
        chk_std(CFSG_PECL);
        nrst = 1'b0;
        wt(1);
        chk("fanout_out", 5'h00, q);
        chk("fanout_out_comp", 5'h1f, qc);
        chk_std(CFSG_LVDS);
        wt(1);
        lvl = 1'b0;
        gate_n = 1'b0;
        nrst = 1'b1;
        pair(5'h1f);
        chk_std(CFSG_LVDS);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wt(2);
        nrst = 1'b1;
        test_reset();
        test_primary();
        test_gate();
        test_level();
        test_reset_mid();
        stop_test();
    end
    // hang guard: a run past this point is a failure
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
